// *** sfc_frame_cfg.sv ***
// status frame configuration registers and status frame sequencer
//
// Functional notes
// - setup register reachable only on page five
// - bits 12:11 pick frame source address
// - bits 10:8 set preamble byte count
// - bit 7 swaps bytes of the 16-bit message word
// - bit 6 picks layer-2 or ipv4 frames
// - bit 5 returns control read data
// - bit 4 reports status frame errors
// - error enable alone never generates frames
// - bits 15:13 ignore writes, read zero
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
module sfc_frame_cfg (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [4:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [15:0] rd_data,
    input wire logic msg_valid,
    input wire logic [1:0] msg_kind,
    input wire logic [15:0] msg_data,
    output logic msg_ready,
    output logic tx_en,
    output logic [7:0] tx_data,
    output logic frame_busy
);
    localparam int CW = $clog2(sfc_pkg::FIFO_DEPTH) + 1;

    logic [2:0] page_sel;
    logic [12:0] setup;
    logic event_en;
    logic [7:0] frames_sent;
    sfc_pkg::sfc_state_e state;
    sfc_pkg::sfc_state_e next_state;
    logic [4:0] idx;
    logic [4:0] next_idx;
    logic [2:0] pre_cnt;
    logic [2:0] next_pre_cnt;
    logic [3:0] gap_cnt;
    logic [3:0] next_gap_cnt;
    logic [7:0] next_tx_data;
    logic next_tx_en;
    logic [6:0] snap_cfg;
    logic [17:0] cur_msg;
    logic [2:0] pre_seen;
    logic [CW-1:0] fifo_count;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [17:0] fifo_out_data;

    // register decode
    wire logic page_hit = page_sel == sfc_pkg::SETUP_PAGE;
    wire logic wr_page = wr_strobe && addr == sfc_pkg::PAGE_SEL_ADDR;
    wire logic wr_setup = wr_strobe && page_hit && addr == sfc_pkg::SETUP_ADDR;
    wire logic wr_event = wr_strobe && page_hit && addr == sfc_pkg::EVENT_EN_ADDR;
    wire logic rd_setup = page_hit && addr == sfc_pkg::SETUP_ADDR;
    wire logic rd_event = page_hit && addr == sfc_pkg::EVENT_EN_ADDR;
    wire logic rd_status = page_hit && addr == sfc_pkg::STATUS_ADDR;
    wire logic rd_page = addr == sfc_pkg::PAGE_SEL_ADDR;
    wire logic [15:0] status_word = {frames_sent, 3'h0, fifo_count, frame_busy};
    wire logic [15:0] next_rd_data =
        rd_setup ? {3'h0, setup} :
        rd_event ? {15'h0000, event_en} :
        rd_status ? status_word :
        rd_page ? {13'h0000, page_sel} : 16'h0000;

    // message filtering; disabled kinds are accepted and dropped
    wire logic ctl_rd_en = setup[sfc_pkg::CTL_RD_BIT];
    wire logic err_en = setup[sfc_pkg::ERR_BIT];
    wire logic gen_on = ctl_rd_en || event_en;
    wire logic msg_take = msg_valid && msg_ready;
    wire logic keep_ctl = msg_kind == sfc_pkg::KIND_CTL_READ && ctl_rd_en;
    wire logic keep_err = msg_kind == sfc_pkg::KIND_ERROR && err_en && gen_on;
    wire logic keep_evt = msg_kind == sfc_pkg::KIND_EVENT && event_en;
    wire logic fifo_in_valid = msg_take && (keep_ctl || keep_err || keep_evt);
    wire logic fifo_pop = state == sfc_pkg::ST_IDLE && fifo_out_valid;
    // one slot of slack because ready is registered
    wire logic next_msg_ready = fifo_count <= CW'(sfc_pkg::FIFO_DEPTH - 2);

    // frame contents, taken from the per-frame snapshot
    wire logic [1:0] snap_src = snap_cfg[6:5];
    wire logic [2:0] snap_pre = snap_cfg[4:2];
    wire logic snap_order = snap_cfg[1];
    wire logic snap_ipv4 = snap_cfg[0];
    wire logic [47:0] src_addr =
        snap_src == 2'b00 ? sfc_pkg::MAKER_ADDR_A :
        snap_src == 2'b01 ? sfc_pkg::MAKER_ADDR_B :
        snap_src == 2'b10 ? sfc_pkg::MCAST_DEST : sfc_pkg::ZERO_ADDR;
    wire logic [15:0] frame_type = snap_ipv4 ? sfc_pkg::TYPE_IPV4 : sfc_pkg::TYPE_L2;
    wire logic [15:0] msg_word = cur_msg[15:0];
    wire logic [15:0] msg_ordered =
        snap_order ? {msg_word[7:0], msg_word[15:8]} : msg_word;
    wire logic [135:0] frame_bytes =
        {sfc_pkg::MCAST_DEST, src_addr, frame_type, 6'h00, cur_msg[17:16], msg_ordered};
    wire logic [7:0] byte_base = 8'(8'd128 - {idx, 3'b000});
    wire logic [7:0] body_byte = frame_bytes[byte_base +: 8];

    always_ff @(posedge clk) begin
        if (reset) begin
            page_sel <= sfc_pkg::PAGE_RESET;
            setup <= sfc_pkg::SETUP_RESET;
            event_en <= sfc_pkg::EVENT_EN_RESET;
        end else if (ce) begin
            if (wr_page) begin
                page_sel <= wr_data[2:0];
            end
            if (wr_setup) begin
                setup <= wr_data[sfc_pkg::STORED_HI:0];
            end
            if (wr_event) begin
                event_en <= wr_data[0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rd_data <= 16'h0000;
            msg_ready <= 1'b0;
        end else if (ce) begin
            rd_data <= rd_strobe ? next_rd_data : 16'h0000;
            msg_ready <= next_msg_ready;
        end
    end

    // sequencer next state
    always_comb begin
        next_state = state;
        next_idx = idx;
        next_pre_cnt = pre_cnt;
        next_gap_cnt = gap_cnt;
        next_tx_en = 1'b0;
        next_tx_data = 8'h00;
        unique case (state)
            sfc_pkg::ST_IDLE: begin
                if (fifo_out_valid) begin
                    next_pre_cnt = setup[sfc_pkg::PRE_HI:sfc_pkg::PRE_LO];
                    next_state = sfc_pkg::ST_PRE;
                end
            end
            sfc_pkg::ST_PRE: begin
                if (pre_cnt == 3'h0) begin
                    next_tx_en = 1'b1;
                    next_tx_data = sfc_pkg::SFD_BYTE;
                    next_idx = 5'h00;
                    next_state = sfc_pkg::ST_SFD;
                end else begin
                    next_tx_en = 1'b1;
                    next_tx_data = sfc_pkg::PREAMBLE_BYTE;
                    next_pre_cnt = pre_cnt - 3'h1;
                end
            end
            sfc_pkg::ST_SFD, sfc_pkg::ST_BODY: begin
                next_tx_en = 1'b1;
                next_tx_data = body_byte;
                next_idx = idx + 5'h01;
                next_state = sfc_pkg::ST_BODY;
                if (idx == sfc_pkg::LAST_IDX) begin
                    next_gap_cnt = sfc_pkg::GAP_BYTES;
                    next_state = sfc_pkg::ST_GAP;
                end
            end
            sfc_pkg::ST_GAP: begin
                next_gap_cnt = gap_cnt - 4'h1;
                if (gap_cnt == 4'h1) begin
                    next_state = sfc_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = sfc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= sfc_pkg::ST_IDLE;
            idx <= 5'h00;
            pre_cnt <= 3'h0;
            gap_cnt <= 4'h0;
            tx_en <= 1'b0;
            tx_data <= 8'h00;
        end else if (ce) begin
            state <= next_state;
            idx <= next_idx;
            pre_cnt <= next_pre_cnt;
            gap_cnt <= next_gap_cnt;
            tx_en <= next_tx_en;
            tx_data <= next_tx_data;
        end
    end

    // snapshot at frame start so a write mid-frame cannot tear it
    always_ff @(posedge clk) begin
        if (reset) begin
            snap_cfg <= 7'h00;
            cur_msg <= 18'h00000;
            frames_sent <= 8'h00;
            frame_busy <= 1'b0;
        end else if (ce) begin
            frame_busy <= next_state != sfc_pkg::ST_IDLE;
            if (fifo_pop) begin
                snap_cfg <= setup[sfc_pkg::SRC_SEL_HI:sfc_pkg::IPV4_BIT];
                cur_msg <= fifo_out_data;
            end
            if (state == sfc_pkg::ST_BODY && idx == sfc_pkg::LAST_IDX) begin
                frames_sent <= frames_sent + 8'h01;
            end
        end
    end

    sfc_fifo #(
        .WIDTH(sfc_pkg::MSG_WIDTH),
        .DEPTH(sfc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data({msg_kind, msg_data}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data),
        .count(fifo_count)
    );

    // helper: preamble bytes sent in the current frame
    always_ff @(posedge clk) begin
        if (reset) begin
            pre_seen <= 3'h0;
        end else if (ce) begin
            if (state == sfc_pkg::ST_IDLE) begin
                pre_seen <= 3'h0;
            end else if (state == sfc_pkg::ST_PRE && pre_cnt != 3'h0) begin
                pre_seen <= pre_seen + 3'h1;
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    page_gate_a: assert property (
        (ce && wr_strobe && addr == sfc_pkg::SETUP_ADDR && !page_hit) |=> $stable(setup))
        else $error("setup written off its page");

    src_addr_a: assert property (
        (ce && state == sfc_pkg::ST_BODY && idx == sfc_pkg::SRC_FIRST_IDX)
        |=> tx_data == $past(src_addr[47:40]))
        else $error("wrong source address byte");

    preamble_len_a: assert property (
        (state == sfc_pkg::ST_SFD) |-> pre_seen == snap_pre)
        else $error("preamble count differs from setting");

    byte_order_a: assert property (
        (ce && state == sfc_pkg::ST_BODY && idx == sfc_pkg::MSG_FIRST_IDX)
        |=> tx_data == ($past(snap_order) ? $past(cur_msg[7:0]) : $past(cur_msg[15:8])))
        else $error("message byte order wrong");

    frame_type_a: assert property (
        (ce && state == sfc_pkg::ST_BODY && idx == sfc_pkg::TYPE_FIRST_IDX)
        |=> tx_data == ($past(snap_ipv4) ? sfc_pkg::TYPE_IPV4[15:8] : sfc_pkg::TYPE_L2[15:8]))
        else $error("frame type byte wrong");

    ctl_return_a: assert property (
        (msg_take && msg_kind == sfc_pkg::KIND_CTL_READ) |-> (fifo_in_valid == ctl_rd_en))
        else $error("control read data mishandled");

    err_report_a: assert property (
        (msg_take && msg_kind == sfc_pkg::KIND_ERROR && err_en && gen_on) |-> fifo_in_valid)
        else $error("enabled error not queued");

    err_alone_a: assert property (
        (msg_take && msg_kind == sfc_pkg::KIND_ERROR && !gen_on) |-> !fifo_in_valid)
        else $error("error enable alone started frames");

    rsvd_zero_a: assert property (
        (ce && rd_strobe && rd_setup) |=> rd_data[15:13] == 3'h0)
        else $error("reserved bits read nonzero");

    snap_hold_a: assert property (
        (state != sfc_pkg::ST_IDLE && $past(state) != sfc_pkg::ST_IDLE) |-> $stable(snap_cfg))
        else $error("config changed inside a frame");

    page_read_a: assert property (
        (ce && rd_strobe && addr == sfc_pkg::SETUP_ADDR && !page_hit) |=> rd_data == 16'h0000)
        else $error("setup read off its page");

    rd_idle_a: assert property (
        (ce && !rd_strobe) |=> rd_data == 16'h0000)
        else $error("read data outside its slot");

    ce_freeze_a: assert property (
        !ce |=> $stable(setup) && $stable(state) && $stable(tx_data))
        else $error("state moved with enable low");

    frame_done_c: cover property (state == sfc_pkg::ST_GAP && gap_cnt == 4'h1);
    ipv4_frame_c: cover property (state == sfc_pkg::ST_BODY && snap_ipv4);
    swapped_c: cover property (state == sfc_pkg::ST_BODY && snap_order);
    fifo_full_c: cover property (!fifo_in_ready);
    event_frame_c: cover property (fifo_pop && fifo_out_data[17:16] == sfc_pkg::KIND_EVENT);
endmodule
`default_nettype wire

// *** sfc_pkg.sv ***
// shared constants and types for the status frame configuration block
package sfc_pkg;
    // register offsets, in the register page space
    localparam logic [4:0] PAGE_SEL_ADDR = 5'h13;
    localparam logic [4:0] SETUP_ADDR = 5'h18;
    localparam logic [4:0] EVENT_EN_ADDR = 5'h19;
    localparam logic [4:0] STATUS_ADDR = 5'h1A;
    localparam logic [2:0] SETUP_PAGE = 3'h5;

    // status_frame_setup field positions
    localparam int SRC_SEL_HI = 12;
    localparam int PRE_HI = 10;
    localparam int PRE_LO = 8;
    localparam int ORDER_BIT = 7;
    localparam int IPV4_BIT = 6;
    localparam int CTL_RD_BIT = 5;
    localparam int ERR_BIT = 4;
    localparam int STORED_HI = 12;

    // reset values
    localparam logic [12:0] SETUP_RESET = 13'h0000;
    localparam logic [2:0] PAGE_RESET = 3'h0;
    localparam logic EVENT_EN_RESET = 1'b0;

    // addresses; the values are arbitrary
    localparam logic [47:0] MAKER_ADDR_A = 48'h0200_0000_0001;
    localparam logic [47:0] MAKER_ADDR_B = 48'h0200_0000_0002;
    localparam logic [47:0] MCAST_DEST = 48'h0100_0000_0001;
    localparam logic [47:0] ZERO_ADDR = 48'h0000_0000_0000;

    // frame layout
    localparam logic [15:0] TYPE_L2 = 16'h88B5;
    localparam logic [15:0] TYPE_IPV4 = 16'h0800;
    localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
    localparam logic [7:0] SFD_BYTE = 8'hD5;
    localparam logic [4:0] SRC_FIRST_IDX = 5'h06;
    localparam logic [4:0] TYPE_FIRST_IDX = 5'h0C;
    localparam logic [4:0] MSG_FIRST_IDX = 5'h0F;
    localparam logic [4:0] LAST_IDX = 5'h10;
    localparam logic [3:0] GAP_BYTES = 4'hC;

    localparam int FIFO_DEPTH = 8;
    localparam int MSG_WIDTH = 18;

    typedef enum logic [1:0] {
        KIND_CTL_READ = 2'b00,
        KIND_ERROR = 2'b01,
        KIND_EVENT = 2'b10,
        KIND_SPARE = 2'b11
    } sfc_kind_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PRE = 3'b001,
        ST_SFD = 3'b010,
        ST_BODY = 3'b011,
        ST_GAP = 3'b100
    } sfc_state_e;
endpackage

// *** sfc_fifo.sv ***
// message fifo between the accept logic and the frame sequencer
`timescale 1ns/1ps
`default_nettype none
module sfc_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;

    wire logic push = ce && in_valid && in_ready;
    wire logic pop = ce && out_valid && out_ready;

    assign in_ready = count != (AW+1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

    fifo_bound_a: assert property (@(posedge clk) disable iff (reset)
        count <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
endmodule
`default_nettype wire

// *** sfc_mac_model.sv ***
// behavioural mac that receives status frames from the frame sequencer
`timescale 1ns/1ps
`default_nettype none
module sfc_mac_model #(
    parameter int MIN_ACCEPT = 0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic tx_en,
    input wire logic [7:0] tx_data,
    output logic [7:0] frames,
    output logic [7:0] pre_len,
    output logic [4:0] body_len,
    output logic pre_ok,
    output logic [7:0] fb [0:16]
);
    logic prev_en;
    logic in_body;
    logic [4:0] idx;
    wire logic start = tx_en && !prev_en;
    wire logic is_sfd = (tx_data == sfc_pkg::SFD_BYTE);

    always_ff @(posedge clk) begin
        if (reset) begin
            prev_en <= 1'b0;
            in_body <= 1'b0;
            idx <= 5'h00;
            frames <= 8'h00;
            pre_len <= 8'h00;
            body_len <= 5'h00;
            pre_ok <= 1'b1;
        end else begin
            prev_en <= tx_en;
            if (start) begin
                idx <= 5'h00;
                in_body <= is_sfd;
                pre_len <= is_sfd ? 8'h00 : 8'h01;
            end else if (tx_en && !in_body) begin
                if (is_sfd) begin
                    in_body <= 1'b1;
                end else begin
                    pre_len <= pre_len + 8'h01;
                end
            end else if (tx_en) begin
                if (idx <= 5'h10) begin
                    fb[idx] <= tx_data;
                end
                idx <= idx + 5'h01;
            end
            if (!tx_en && prev_en) begin
                frames <= frames + 8'h01;
                body_len <= idx;
                // a mac refuses preambles shorter than it can lock onto
                pre_ok <= (pre_len >= 8'(MIN_ACCEPT));
                in_body <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** test_status_frame_config.sv ***
// self-checking bench for the status frame configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_status_frame_config;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic [4:0] addr = 5'h00;
    logic [15:0] wr_data = 16'h0000;
    logic wr_strobe = 1'b0;
    logic rd_strobe = 1'b0;
    logic [15:0] rd_data;
    logic msg_valid = 1'b0;
    logic [1:0] msg_kind = 2'b00;
    logic [15:0] msg_data = 16'h0000;
    logic msg_ready, tx_en, frame_busy, pre_ok;
    logic [7:0] tx_data, frames, pre_len;
    logic [4:0] body_len;
    logic [7:0] fb [0:16];
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [15:0] rv;
    logic [15:0] cfg [0:3] = '{16'h0020, 16'h0BE0, 16'h1720, 16'h1DF0};

    always #50 clk = ~clk;

    sfc_frame_cfg DUT (.clk(clk), .reset(reset), .ce(ce), .addr(addr), .wr_data(wr_data),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
        .msg_valid(msg_valid), .msg_kind(msg_kind), .msg_data(msg_data),
        .msg_ready(msg_ready), .tx_en(tx_en), .tx_data(tx_data), .frame_busy(frame_busy));

    sfc_mac_model #(.MIN_ACCEPT(0)) mac (.clk(clk), .reset(reset), .tx_en(tx_en),
        .tx_data(tx_data), .frames(frames), .pre_len(pre_len), .body_len(body_len),
        .pre_ok(pre_ok), .fb(fb));

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk) begin wr_strobe <= 1'b1; addr <= a; wr_data <= d; end
        @(posedge clk) wr_strobe <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk) begin rd_strobe <= 1'b1; addr <= a; end
        @(posedge clk) rd_strobe <= 1'b0;
        #1 d = rd_data;
    endtask

    // message held until taken; ready is only trusted at the sampling edge
    task automatic send(input logic [1:0] k, input logic [15:0] d);
        @(posedge clk) begin msg_valid <= 1'b1; msg_kind <= k; msg_data <= d; end
        do @(posedge clk); while (msg_ready !== 1'b1);
        msg_valid <= 1'b0;
    endtask

    task automatic wait_frame(input logic [7:0] n);
        for (int i = 0; i < 400 && frames !== n; i++) @(posedge clk);
        `CHK(frames, n)
    endtask

    // expectations come from the setup word that sent the frame
    task automatic check_frame(input logic [15:0] s, input logic [1:0] k, input logic [15:0] d);
        logic [47:0] src;
        logic [15:0] ty;
        case (s[12:11])
            2'b00: src = sfc_pkg::MAKER_ADDR_A;
            2'b01: src = sfc_pkg::MAKER_ADDR_B;
            2'b10: src = sfc_pkg::MCAST_DEST;
            default: src = sfc_pkg::ZERO_ADDR;
        endcase
        ty = s[6] ? sfc_pkg::TYPE_IPV4 : sfc_pkg::TYPE_L2;
        `CHK(pre_len, {5'h00, s[10:8]})
        `CHK(pre_ok, 1'b1)
        `CHK(body_len, 5'h11)
        for (int i = 0; i < 6; i++) begin
            `CHK(fb[i], sfc_pkg::MCAST_DEST[47 - 8 * i -: 8])
            `CHK(fb[6 + i], src[47 - 8 * i -: 8])
        end
        `CHK({fb[12], fb[13]}, ty)
        `CHK(fb[14], {6'h00, k})
        `CHK({fb[15], fb[16]}, s[7] ? {d[7:0], d[15:8]} : d)
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // hang guard: the whole sequence needs about a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        // page gating, reserved bits and unmapped space
        wr(sfc_pkg::SETUP_ADDR, 16'h0FF0);
        rd(sfc_pkg::SETUP_ADDR, rv);
        `CHK(rv, 16'h0000)
        wr(sfc_pkg::PAGE_SEL_ADDR, 16'h0005);
        rd(sfc_pkg::SETUP_ADDR, rv);
        `CHK(rv, 16'h0000)
        wr(sfc_pkg::SETUP_ADDR, 16'hFFF0);
        rd(sfc_pkg::SETUP_ADDR, rv);
        `CHK(rv, 16'h1FF0)
        rd(5'h05, rv);
        `CHK(rv, 16'h0000)
        // a write while the enable is low must not land
        @(posedge clk) ce <= 1'b0;
        wr(sfc_pkg::SETUP_ADDR, 16'h0120);
        ce <= 1'b1;
        rd(sfc_pkg::SETUP_ADDR, rv);
        `CHK(rv, 16'h1FF0)
        wr(sfc_pkg::SETUP_ADDR, 16'h0000);
        $display("register test done");
        // every source code, preamble edge values, both orders and types
        for (int i = 0; i < 4; i++) begin
            wr(sfc_pkg::SETUP_ADDR, cfg[i]);
            send(i == 3 ? 2'b01 : 2'b00, 16'hA51C + 16'(i));
            wait_frame(8'(i + 1));
            check_frame(cfg[i], i == 3 ? 2'b01 : 2'b00, 16'hA51C + 16'(i));
        end
        $display("frame format test done");
        // error enable alone must stay silent
        wr(sfc_pkg::SETUP_ADDR, 16'h0010);
        send(2'b01, 16'h1234);
        repeat (80) @(posedge clk);
        `CHK(frames, 8'h04)
        `CHK(frame_busy, 1'b0)
        $display("error enable test done");
        // a setup change mid-frame only reaches the following frame
        wr(sfc_pkg::SETUP_ADDR, 16'h0320);
        send(2'b00, 16'hBEEF);
        for (int i = 0; i < 100 && frame_busy !== 1'b1; i++) @(posedge clk);
        wr(sfc_pkg::SETUP_ADDR, 16'h18A0);
        wait_frame(8'h05);
        check_frame(16'h0320, 2'b00, 16'hBEEF);
        send(2'b00, 16'hC0DE);
        wait_frame(8'h06);
        check_frame(16'h18A0, 2'b00, 16'hC0DE);
        $display("mid-frame change test done");
        // event enable lets the error kind through; the spare kind is dropped
        wr(sfc_pkg::EVENT_EN_ADDR, 16'h0001);
        rd(sfc_pkg::EVENT_EN_ADDR, rv);
        `CHK(rv, 16'h0001)
        wr(sfc_pkg::SETUP_ADDR, 16'h0010);
        send(2'b01, 16'h5A5A);
        wait_frame(8'h07);
        check_frame(16'h0010, 2'b01, 16'h5A5A);
        send(2'b10, 16'h0F0F);
        send(2'b11, 16'h7777);
        wait_frame(8'h08);
        check_frame(16'h0010, 2'b10, 16'h0F0F);
        repeat (80) @(posedge clk);
        `CHK(frames, 8'h08)
        rd(sfc_pkg::STATUS_ADDR, rv);
        `CHK(rv, 16'h0800)
        $display("event test done");
        // a burst deeper than the fifo stalls the sender but loses nothing
        wr(sfc_pkg::SETUP_ADDR, 16'h0020);
        for (int i = 0; i < 10; i++) begin
            send(2'b00, 16'(i));
        end
        wait_frame(8'h12);
        check_frame(16'h0020, 2'b00, 16'h0009);
        $display("burst test done");
        // reset in mid-run returns page, setup and event enable to zero
        @(posedge clk) reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(sfc_pkg::SETUP_ADDR, rv);
        `CHK(rv, 16'h0000)
        wr(sfc_pkg::PAGE_SEL_ADDR, 16'h0005);
        rd(sfc_pkg::SETUP_ADDR, rv);
        `CHK(rv, 16'h0000)
        rd(sfc_pkg::EVENT_EN_ADDR, rv);
        `CHK(rv, 16'h0000)
        `CHK(frames, 8'h00)
        $display("reset test done");
        results();
    end
endmodule
`default_nettype wire
